// ==== shared/rsq_pkg.sv ====
package rsq_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned WAKE_FILTER_NS = 167000;
	// Least time: rounds up to whole cycles
	localparam int unsigned WAKE_FILTER_CYC = (WAKE_FILTER_NS * 40 + 999) / 1000;
	localparam int unsigned CARRY_PERIOD_MS = 100;
	localparam int unsigned CARRY_PERIOD_CYC_DEF = CARRY_PERIOD_MS * (CLK_HZ / 1000);
	localparam int unsigned CARRY_HALF_CYC_DEF = CARRY_PERIOD_CYC_DEF / 2;
	localparam int unsigned FILTER_W = 13;

	// ----------------------------------------
	// Field values
	// ----------------------------------------
	localparam logic [3:0] WAKE_COUNT_RST = 4'h1;
	localparam logic [3:0] WAKE_COUNT_ZERO = 4'h0;
	localparam logic [13:0] RESTART_ADDR = 14'h0000;

	typedef enum logic [1:0] {
		RSQ_CLEAR,
		RSQ_HALT_WAIT,
		RSQ_RUN
	} rsq_state_t;

	// Status toward the core
	typedef struct packed {
		logic osc_stop;
		logic core_init;
		logic halt;
		logic restart;
		logic high_threshold;
	} rsq_ctl_t;

endpackage

// ==== core/rsq_filter.sv ====
`timescale 1ns/1ps
`default_nettype none
module rsq_filter #(
	parameter int unsigned LEN = 8,
	parameter int unsigned W = 13
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Raw and filtered level
	input wire logic din,
	output logic dout
);
	logic sync1_ff;
	logic sync2_ff;
	logic [W-1:0] cnt_ff;
	logic dout_ff;

	// ----------------------------------------
	// Two-stage synchroniser
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
		end
		else
		begin
			sync1_ff <= din;
			sync2_ff <= sync1_ff;
		end
	end

	// ----------------------------------------
	// Level must stand LEN cycles to pass
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_ff <= '0;
			dout_ff <= 1'b0;
		end
		else if (sync2_ff == dout_ff)
			cnt_ff <= '0;
		else if (cnt_ff == W'(LEN - 1))
		begin
			cnt_ff <= '0;
			dout_ff <= sync2_ff;
		end
		else
			cnt_ff <= cnt_ff + W'(1);
	end

	assign dout = dout_ff;
endmodule
`default_nettype wire

// ==== core/rsq_sequencer.sv ====
// Summary of operation
// R1: A wake reset acts at once, aborting the running instruction without waiting for a boundary.
// R2: The supply-low clear input is taken as asserted whenever supply is below the chosen threshold.
// R3: While supply-low clear is asserted the oscillator is held stopped.
// R4: Supply-low clear initialises program counter, stack, system and control registers.
// R5: On release the oscillator restarts, the core stays halted and the carry period reloads to 100 ms.
// R6: Execution resumes at address 0 on the first carry set pulse, 50 ms after release.
// R7: The high threshold is selected in normal running and the low one in clock stop.
// R8: In normal running a drop below the high threshold clears the device whatever the wake pin does.
// R9: The halt instruction state counts as normal running; only clock stop selects the low threshold.
// R10: After the wake pin rises, carry set pulses are counted and a wake reset fires at the set count 1 to 15.
// R11: Wake pin levels shorter than 167 us are ignored as noise.
// R12: A wake reset initialises core state and starts execution at address 0000H.
// R13: Both inputs are synchronised, and supply-low clear wins over any pending wake reset.
`timescale 1ns/1ps
`default_nettype none
module rsq_sequencer #(
	parameter int unsigned CARRY_PERIOD_CYC = rsq_pkg::CARRY_PERIOD_CYC_DEF,
	parameter int unsigned CARRY_HALF_CYC = rsq_pkg::CARRY_HALF_CYC_DEF,
	parameter int unsigned WAKE_FILTER_CYC = rsq_pkg::WAKE_FILTER_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Detector and wake pin
	input wire logic supply_low_clear,
	input wire logic wake_pin,
	// Core status
	input wire logic clock_stop_req,
	input wire logic wake_count_we,
	input wire logic [3:0] wake_count_wdata,
	// Outputs toward core
	output rsq_pkg::rsq_ctl_t ctl,
	output logic [13:0] restart_addr,
	output logic carry_pulse
);
	rsq_pkg::rsq_state_t state_ff;
	rsq_pkg::rsq_state_t nxt_state;
	logic clr_s1_ff;
	logic clr_s2_ff;
	logic wake_lvl;
	logic wake_lvl_ff;
	logic clock_stop_ff;
	logic [3:0] wake_set_ff;
	logic [3:0] wake_cnt_ff;
	logic wake_arm_ff;
	logic [31:0] carry_cnt_ff;
	logic carry_tick;
	logic wake_fire;
	logic wake_rise;
	logic restart_ff;

	// ----------------------------------------
	// Input conditioning
	// ----------------------------------------
	// R13: clear synchroniser
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			clr_s1_ff <= 1'b1;
			clr_s2_ff <= 1'b1;
		end
		else
		begin
			clr_s1_ff <= supply_low_clear;
			clr_s2_ff <= clr_s1_ff;
		end
	end

	// R11: wake noise filter
	rsq_filter #(
		.LEN(WAKE_FILTER_CYC),
		.W(rsq_pkg::FILTER_W)
	) rsq_filter_inst (
		.clk(clk),
		.rst(rst),
		.din(wake_pin),
		.dout(wake_lvl)
	);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			wake_lvl_ff <= 1'b0;
		else
			wake_lvl_ff <= wake_lvl;
	end

	assign wake_rise = wake_lvl & ~wake_lvl_ff;

	// ----------------------------------------
	// Clock-stop state and threshold
	// ----------------------------------------
	// R9: only clock stop lowers threshold
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			clock_stop_ff <= 1'b0;
		else if (clr_s2_ff || wake_rise)
			clock_stop_ff <= 1'b0;
		else if (clock_stop_req && state_ff == rsq_pkg::RSQ_RUN)
			clock_stop_ff <= 1'b1;
	end

	// ----------------------------------------
	// Base timer 0 carry
	// ----------------------------------------
	// R5: period reloads on clear
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			carry_cnt_ff <= '0;
		else if (clr_s2_ff)
			carry_cnt_ff <= '0;
		else if (clock_stop_ff)
			carry_cnt_ff <= carry_cnt_ff;
		else if (carry_cnt_ff == 32'(CARRY_PERIOD_CYC - 1))
			carry_cnt_ff <= '0;
		else
			carry_cnt_ff <= carry_cnt_ff + 32'h1;
	end

	// R6: first set pulse at half period
	assign carry_tick = !clr_s2_ff && !clock_stop_ff && carry_cnt_ff == 32'(CARRY_HALF_CYC - 1);

	// ----------------------------------------
	// Wake reset counter
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			wake_set_ff <= rsq_pkg::WAKE_COUNT_RST;
		else if (clr_s2_ff || clock_stop_ff)
			wake_set_ff <= rsq_pkg::WAKE_COUNT_RST;
		else if (wake_count_we && wake_count_wdata != rsq_pkg::WAKE_COUNT_ZERO)
			wake_set_ff <= wake_count_wdata;
	end

	// R10: count carry pulses after rise
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wake_arm_ff <= 1'b0;
			wake_cnt_ff <= rsq_pkg::WAKE_COUNT_ZERO;
		end
		else if (clr_s2_ff)
		begin
			wake_arm_ff <= 1'b0;
			wake_cnt_ff <= rsq_pkg::WAKE_COUNT_ZERO;
		end
		// New rise wins over a fire in the same cycle
		else if (wake_rise)
		begin
			wake_arm_ff <= 1'b1;
			wake_cnt_ff <= rsq_pkg::WAKE_COUNT_ZERO;
		end
		else if (wake_fire)
		begin
			wake_arm_ff <= 1'b0;
			wake_cnt_ff <= rsq_pkg::WAKE_COUNT_ZERO;
		end
		else if (wake_arm_ff && carry_tick)
			wake_cnt_ff <= wake_cnt_ff + 4'h1;
	end

	// R10: fire on count match
	assign wake_fire = wake_arm_ff && carry_tick && (wake_cnt_ff + 4'h1) == wake_set_ff;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			rsq_pkg::RSQ_CLEAR:
				// R5: restart then halt
				if (!clr_s2_ff)
					nxt_state = rsq_pkg::RSQ_HALT_WAIT;
			rsq_pkg::RSQ_HALT_WAIT:
				// R6: carry releases halt
				if (carry_tick)
					nxt_state = rsq_pkg::RSQ_RUN;
			rsq_pkg::RSQ_RUN:
				nxt_state = rsq_pkg::RSQ_RUN;
			default:
				nxt_state = rsq_pkg::RSQ_CLEAR;
		endcase
		// R8: clear regardless of wake pin
		if (clr_s2_ff)
			nxt_state = rsq_pkg::RSQ_CLEAR;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_ff <= rsq_pkg::RSQ_CLEAR;
		else
			state_ff <= nxt_state;
	end

	// R1: abort mid-instruction, R12: restart at zero
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			restart_ff <= 1'b0;
		else
			restart_ff <= !clr_s2_ff && (wake_fire
				|| (state_ff == rsq_pkg::RSQ_HALT_WAIT && carry_tick));
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			restart_addr <= rsq_pkg::RESTART_ADDR;
		else
			restart_addr <= rsq_pkg::RESTART_ADDR;
	end

	// R2: clear forwarded, R3: oscillator stopped
	assign ctl.osc_stop = clr_s2_ff || clock_stop_ff;
	// R4: init during clear, R13: clear wins
	assign ctl.core_init = clr_s2_ff || restart_ff;
	assign ctl.halt = state_ff != rsq_pkg::RSQ_RUN;
	assign ctl.restart = restart_ff;
	// R7: threshold select
	assign ctl.high_threshold = !clock_stop_ff;
	assign carry_pulse = carry_tick;
endmodule
`default_nettype wire

// ==== tb/rsq_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module rsq_far (
	// Threshold select
	input wire logic high_threshold,
	// Toward the device
	output var logic supply_low_clear,
	output var logic wake_pin
);
	int vdd_mv = 0;
	logic wake_lvl = 1'b0;
	assign supply_low_clear = vdd_mv < (high_threshold ? 3500 : 2200);
	assign wake_pin = wake_lvl;
endmodule
`default_nettype wire

// ==== tb/rsq_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module rsq_mon #(
	parameter int CARRY_HALF_CYC = 20
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Watched ports
	input wire logic supply_low_clear,
	input wire rsq_pkg::rsq_ctl_t ctl,
	input wire logic [13:0] restart_addr,
	input wire logic carry_pulse
);
	localparam int LO = CARRY_HALF_CYC - 9;
	localparam int HI = CARRY_HALF_CYC - 1;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	// ----
	// Checks
	// ----
	a_osc_in_clear:
	assert property (supply_low_clear [*3] |-> ctl.osc_stop) else $error("osc runs");
	a_init_in_clear:
	assert property (supply_low_clear [*4] |-> ctl.core_init && ctl.halt && !ctl.restart) else $error("no init");
	a_restart_addr:
	assert property (ctl.restart |-> restart_addr == 14'h0000) else $error("bad addr");
	a_restart_once:
	assert property (ctl.restart |=> !ctl.restart) else $error("long restart");
	a_restart_run:
	assert property (ctl.restart |-> !ctl.halt && ctl.core_init) else $error("bad restart");
	a_thr_running:
	assert property ((!ctl.osc_stop || ctl.halt) |-> ctl.high_threshold) else $error("low thr");
	a_clear_to_run:
	assert property ($fell(supply_low_clear) |-> (!ctl.restart) [*8] ##[LO:HI] ctl.restart) else $error("late");
	a_carry_single:
	assert property (carry_pulse |=> !carry_pulse) else $error("long carry");
endmodule
bind rsq_sequencer rsq_mon #(.CARRY_HALF_CYC(CARRY_HALF_CYC)) rsq_mon_inst (.clk(clk), .rst(rst),
	.supply_low_clear(supply_low_clear), .ctl(ctl), .restart_addr(restart_addr), .carry_pulse(carry_pulse));
`default_nettype wire

// ==== tb/tb_rsq_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_rsq_sequencer;
	localparam int HALF = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic supply_low_clear;
	logic wake_pin;
	logic clock_stop_req = 1'b0;
	logic wake_count_we = 1'b0;
	logic [3:0] wake_count_wdata = 4'h1;
	rsq_pkg::rsq_ctl_t ctl;
	logic [13:0] restart_addr;
	logic carry_pulse;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n;
	rsq_sequencer #(.CARRY_PERIOD_CYC(40), .CARRY_HALF_CYC(HALF), .WAKE_FILTER_CYC(4)) rsq_sequencer_inst (
		.clk(clk), .rst(rst), .supply_low_clear(supply_low_clear), .wake_pin(wake_pin),
		.clock_stop_req(clock_stop_req), .wake_count_we(wake_count_we), .wake_count_wdata(wake_count_wdata),
		.ctl(ctl), .restart_addr(restart_addr), .carry_pulse(carry_pulse));
	rsq_far rsq_far_inst (.high_threshold(ctl.high_threshold), .supply_low_clear(supply_low_clear),
		.wake_pin(wake_pin));
	initial forever #12.5 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			num_errors++;
			end_sim();
		end
	end
	task automatic end_sim();
		if (num_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task automatic wait_restart(input int lim);
		n = 0;
		while (ctl.restart !== 1'b1 && n < lim)
		begin
			step(1);
			n++;
		end
	endtask
	task automatic t_clear_release();
		rsq_far_inst.vdd_mv = 5000;
		wait_restart(200);
		check(16'(n >= HALF && n <= HALF + 5), 16'h0001);
		check(16'(ctl), 16'h000b);
	endtask
	task automatic t_wake(input logic [3:0] w, input int cnt);
		int p;
		p = 0;
		wake_count_wdata = w;
		wake_count_we = 1'b1;
		step(1);
		wake_count_we = 1'b0;
		for (int i = 0; i < 45 && carry_pulse !== 1'b1; i++) step(1);
		step(10);
		rsq_far_inst.wake_lvl = 1'b1;
		n = 0;
		while (ctl.restart !== 1'b1 && n < 1000)
		begin
			step(1);
			n++;
			if (carry_pulse === 1'b1)
				p++;
		end
		check(16'(p), 16'(cnt));
		check({2'h0, restart_addr}, 16'h0000);
		rsq_far_inst.wake_lvl = 1'b0;
		step(10);
	endtask
	task automatic t_stop();
		clock_stop_req = 1'b1;
		step(1);
		clock_stop_req = 1'b0;
		rsq_far_inst.vdd_mv = 3000;
		step(5);
		check(16'(ctl), 16'h0010);
		rsq_far_inst.vdd_mv = 5000;
		rsq_far_inst.wake_lvl = 1'b1;
		wait_restart(200);
		check(16'(ctl), 16'h000b);
		rsq_far_inst.wake_lvl = 1'b0;
		step(10);
	endtask
	task automatic t_glitch();
		rsq_far_inst.wake_lvl = 1'b1;
		step(2);
		rsq_far_inst.wake_lvl = 1'b0;
		wait_restart(120);
		check({15'h0, ctl.restart}, 16'h0000);
	endtask
	task automatic t_drop();
		rsq_far_inst.wake_lvl = 1'b1;
		rsq_far_inst.vdd_mv = 3000;
		step(4);
		check(16'(ctl), 16'h001d);
	endtask
	initial
	begin
		step(2);
		rst = 1'b0;
		step(3);
		check(16'(ctl), 16'h001d);
		t_clear_release();
		t_wake(4'h2, 2);
		t_wake(4'h0, 2);
		t_wake(4'hf, 15);
		t_wake(4'h1, 1);
		t_glitch();
		t_stop();
		t_drop();
		t_clear_release();
		end_sim();
	end
endmodule
`default_nettype wire
